// *** design/plx_exec.sv ***
// Decode and execution of pointer loads, no-op and port outputs
// What this block does
// [RULE1] Pointer-load writes file and digit pointers
// [RULE2] Back-to-back pointer loads: only first executes
// [RULE3] Pointer load: top bits 11, x[7:4], y[3:0]
// [RULE4] Bank load copies 2-bit field to bank
// [RULE5] No-op changes nothing, only PC advances
// [RULE6] Bit output drives accumulator bit 0
// [RULE7] Port-zero output copies full accumulator
// [RULE8] One word, one cycle, carry untouched
`timescale 1ns/1ps
module plx_exec
    import plx_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rstn,
    input  wire logic            instr_valid,
    input  wire logic [PLX_IW-1:0] instr,
    input  wire logic [3:0]      acc,
    input  wire logic            carry_in,
    output plx_ptrs_s            ptrs,
    output logic                 single_port,
    output logic [3:0]           port_zero,
    output logic                 carry_out,
    output logic                 pc_advance,
    output logic                 skipped
);
    // Kind of instruction word
    function automatic plx_kind_e plx_decode(input logic [PLX_IW-1:0] w);
        if (w[PLX_PFX_HI:PLX_PFX_LO] == PLX_XY_PREFIX) begin
            return PLX_K_XY;
        end else if ((w & PLX_BANK_MASK) == PLX_OP_BANK) begin
            return PLX_K_BANK;
        end else if (w == PLX_OP_NOP) begin
            return PLX_K_NOP;
        end else if (w == PLX_OP_BIT_OUT) begin
            return PLX_K_BIT_OUT;
        end else if (w == PLX_OP_P0_OUT) begin
            return PLX_K_P0_OUT;
        end else begin
            return PLX_K_OTHER;
        end
    endfunction

    plx_kind_e        kind;
    logic             prev_xy;
    wire logic        is_xy;
    wire logic        skip_now;
    wire logic        do_xy;
    wire logic        do_bank;
    wire logic        do_bit;
    wire logic        do_p0;
    wire logic [3:0]  x_field;
    wire logic [3:0]  y_field;
    wire logic [1:0]  z_field;
    wire plx_ptrs_s   next_ptrs;
    wire logic        next_single_port;
    wire logic [3:0]  next_port_zero;

    assign kind     = plx_decode(instr);
    assign is_xy    = instr_valid && (kind == PLX_K_XY);                // [RULE3]
    assign skip_now = is_xy && prev_xy;                                 // [RULE2]
    assign do_xy    = is_xy && !prev_xy;
    assign do_bank  = instr_valid && (kind == PLX_K_BANK);
    assign do_bit   = instr_valid && (kind == PLX_K_BIT_OUT);
    assign do_p0    = instr_valid && (kind == PLX_K_P0_OUT);

    // Immediate fields of the load words
    assign x_field = instr[PLX_X_HI:PLX_X_LO];                         // [RULE3]
    assign y_field = instr[PLX_Y_HI:PLX_Y_LO];                         // [RULE3]
    assign z_field = instr[PLX_Z_HI:PLX_Z_LO];                         // [RULE4]

    // Next register values; a skipped load keeps the old pair
    assign next_ptrs.file_ptr  = do_xy ? x_field : ptrs.file_ptr;       // [RULE1]
    assign next_ptrs.digit_ptr = do_xy ? y_field : ptrs.digit_ptr;      // [RULE1]
    assign next_ptrs.bank_ptr  = do_bank ? z_field : ptrs.bank_ptr;     // [RULE4]
    assign next_single_port    = do_bit ? acc[PLX_OUT_BIT] : single_port; // [RULE6]
    assign next_port_zero      = do_p0 ? acc : port_zero;               // [RULE7]

    // Chain of pointer loads; any other valid word breaks it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_xy <= 1'b0;
        end else if (instr_valid) begin
            prev_xy <= is_xy;                                           // [RULE2]
        end
    end

    chk_chain_break: assert property (@(posedge clk) disable iff (!rstn) // [RULE2]
        instr_valid && !is_xy |=> !prev_xy)
        else $error("pointer load chain not broken");

    chk_skip_stall: assert property (@(posedge clk) disable iff (!rstn) // [RULE2]
        skip_now |=> $stable(ptrs) && pc_advance)
        else $error("skipped load changed pointers");

    chk_skip_cause: assert property (@(posedge clk) disable iff (!rstn) // [RULE2]
        skipped |-> $past(instr_valid) && $past(instr[PLX_PFX_HI:PLX_PFX_LO]) == PLX_XY_PREFIX)
        else $error("skip without pointer load");

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ptrs <= '{file_ptr: PLX_PTR_RST, digit_ptr: PLX_PTR_RST, bank_ptr: PLX_BANK_RST};
        end else begin
            ptrs <= next_ptrs;                                          // [RULE1] [RULE4]
        end
    end

    chk_xy_load: assert property (@(posedge clk) disable iff (!rstn) // [RULE1]
        do_xy |=> ptrs.file_ptr == $past(instr[7:4]) && ptrs.digit_ptr == $past(instr[3:0]))
        else $error("pointer load wrong");

    chk_xy_skip: assert property (@(posedge clk) disable iff (!rstn) // [RULE2]
        (is_xy ##1 is_xy) |=> $stable(ptrs.file_ptr) && $stable(ptrs.digit_ptr) && skipped)
        else $error("chained pointer load not skipped");

    chk_xy_noskip: assert property (@(posedge clk) disable iff (!rstn) // [RULE2]
        do_xy |=> !skipped && pc_advance)
        else $error("first pointer load marked skipped");

    chk_xy_decode: assert property (@(posedge clk) disable iff (!rstn) // [RULE3]
        instr_valid && instr[PLX_PFX_HI:PLX_PFX_LO] == PLX_XY_PREFIX && !prev_xy
            |=> ptrs.digit_ptr == $past(instr[3:0]) && ptrs.file_ptr == $past(instr[7:4]))
        else $error("pointer decode wrong");

    chk_xy_ports: assert property (@(posedge clk) disable iff (!rstn) // [RULE1]
        do_xy |=> $stable(port_zero) && $stable(single_port) && $stable(ptrs.bank_ptr))
        else $error("pointer load touched other state");

    chk_bank_load: assert property (@(posedge clk) disable iff (!rstn) // [RULE4]
        do_bank |=> ptrs.bank_ptr == $past(instr[1:0]))
        else $error("bank load wrong");

    chk_bank_only: assert property (@(posedge clk) disable iff (!rstn) // [RULE4]
        do_bank |=> $stable(ptrs.file_ptr) && $stable(ptrs.digit_ptr) && !skipped)
        else $error("bank load touched pointers");

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            single_port <= PLX_BIT_RST;
            port_zero   <= PLX_P0_RST;
        end else begin
            single_port <= next_single_port;                            // [RULE6]
            port_zero   <= next_port_zero;                              // [RULE7]
        end
    end

    chk_bit_out: assert property (@(posedge clk) disable iff (!rstn) // [RULE6]
        do_bit |=> single_port == $past(acc[0]) && $stable(port_zero))
        else $error("bit output wrong");

    chk_bit_ptrs: assert property (@(posedge clk) disable iff (!rstn) // [RULE6]
        do_bit |=> $stable(ptrs))
        else $error("bit output changed pointers");

    chk_p0_out: assert property (@(posedge clk) disable iff (!rstn) // [RULE7]
        do_p0 |=> port_zero == $past(acc) && $stable(single_port))
        else $error("port zero output wrong");

    chk_p0_ptrs: assert property (@(posedge clk) disable iff (!rstn) // [RULE7]
        do_p0 |=> $stable(ptrs))
        else $error("port zero output changed pointers");

    chk_p0_carry: assert property (@(posedge clk) disable iff (!rstn) // [RULE8]
        do_p0 |=> carry_out == $past(carry_in))
        else $error("port zero output changed carry");

    // One word per cycle; carry passes through untouched
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc_advance <= 1'b0;
            skipped    <= 1'b0;
            carry_out  <= 1'b0;
        end else begin
            pc_advance <= instr_valid;                                  // [RULE5] [RULE8]
            skipped    <= skip_now;                                     // [RULE2]
            carry_out  <= carry_in;                                     // [RULE8]
        end
    end

    chk_nop_still: assert property (@(posedge clk) disable iff (!rstn) // [RULE5]
        instr_valid && instr == PLX_OP_NOP |=> $stable(ptrs) && $stable(port_zero)
            && $stable(single_port) && pc_advance)
        else $error("no-op changed state");

    chk_nop_carry: assert property (@(posedge clk) disable iff (!rstn) // [RULE5]
        instr_valid && instr == PLX_OP_NOP |=> carry_out == $past(carry_in) && !skipped)
        else $error("no-op changed carry");

    chk_carry_kept: assert property (@(posedge clk) disable iff (!rstn) // [RULE8]
        instr_valid |=> carry_out == $past(carry_in) && pc_advance)
        else $error("carry or cycle wrong");

    chk_pc_pulse: assert property (@(posedge clk) disable iff (!rstn) // [RULE8]
        !instr_valid |=> !pc_advance && !skipped)
        else $error("advance without a word");

    chk_idle_hold: assert property (@(posedge clk) disable iff (!rstn) // [RULE8]
        !instr_valid |=> $stable(ptrs) && $stable(port_zero) && $stable(single_port))
        else $error("state changed without a word");

    chk_other_still: assert property (@(posedge clk) disable iff (!rstn) // [RULE8]
        instr_valid && kind == PLX_K_OTHER |=> $stable(ptrs) && $stable(port_zero)
            && $stable(single_port) && pc_advance)
        else $error("foreign word changed state");
endmodule

// *** inc/plx_pkg.sv ***
// Package for the pointer load and port output execution block
package plx_pkg;
    localparam int          PLX_IW          = 10;
    localparam logic [9:0]  PLX_OP_NOP      = 10'h000;
    localparam logic [9:0]  PLX_OP_BIT_OUT  = 10'h21F;
    localparam logic [9:0]  PLX_OP_P0_OUT   = 10'h220;
    localparam logic [9:0]  PLX_OP_BANK     = 10'h048;
    localparam logic [9:0]  PLX_BANK_MASK   = 10'h3FC;
    localparam logic [1:0]  PLX_XY_PREFIX   = 2'h3;
    localparam logic [3:0]  PLX_PTR_RST     = 4'h0;
    localparam logic [1:0]  PLX_BANK_RST    = 2'h0;
    localparam logic [3:0]  PLX_P0_RST      = 4'h0;
    localparam logic        PLX_BIT_RST     = 1'b0;
    localparam int          PLX_PFX_HI      = 9;
    localparam int          PLX_PFX_LO      = 8;
    localparam int          PLX_X_HI        = 7;
    localparam int          PLX_X_LO        = 4;
    localparam int          PLX_Y_HI        = 3;
    localparam int          PLX_Y_LO        = 0;
    localparam int          PLX_Z_HI        = 1;
    localparam int          PLX_Z_LO        = 0;
    localparam int          PLX_OUT_BIT     = 0;

    typedef enum logic [2:0] {
        PLX_K_OTHER,
        PLX_K_NOP,
        PLX_K_XY,
        PLX_K_BANK,
        PLX_K_BIT_OUT,
        PLX_K_P0_OUT
    } plx_kind_e;

    typedef struct packed {
        logic [3:0] file_ptr;
        logic [3:0] digit_ptr;
        logic [1:0] bank_ptr;
    } plx_ptrs_s;
endpackage

// *** dv/plx_fetch.sv ***
// Fetch stage model that presents words to the executor
`timescale 1ns/1ps
module plx_fetch
    import plx_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              go,
    input  wire logic [PLX_IW-1:0] word,
    output logic                   instr_valid,
    output logic [PLX_IW-1:0]      instr
);
    logic [PLX_IW-1:0] last = '0;
    always @(posedge clk) begin
        if (go) begin
            last <= word;
        end
    end
    // Idle bus shows the inverse of the last word
    assign instr_valid = go;
    assign instr       = go ? word : ~last;
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the pointer load and port output block
`timescale 1ns/1ps
module testbench
    import plx_pkg::*;
;
    logic              clk = 1'b0, rstn = 1'b0, go = 1'b0, cin = 1'b0;
    logic [PLX_IW-1:0] word = '0, instr;
    logic [3:0]        acc = '0, port_zero;
    logic              instr_valid, single_port, carry_out, pc_advance, skipped;
    plx_ptrs_s         ptrs;
    int                fail_count = 0, samples_checked = 0, cycles = 0;
    initial forever #2.5 clk = ~clk;
    plx_fetch u_fetch (.clk(clk), .go(go), .word(word), .instr_valid(instr_valid), .instr(instr));
    plx_exec dut (.clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr), .acc(acc),
        .carry_in(cin), .ptrs(ptrs), .single_port(single_port), .port_zero(port_zero),
        .carry_out(carry_out), .pc_advance(pc_advance), .skipped(skipped));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input logic [9:0] w, input logic [3:0] a, input logic c);
        go = 1'b1;
        word = w;
        acc = a;
        cin = c;
        @(posedge clk);
        #1;
    endtask
    task automatic t_xy();
        step(10'h3A5, 4'h0, 1'b1);
        chk(24'(ptrs), 24'({4'hA, 4'h5, 2'h0}));
        chk(24'({pc_advance, carry_out}), 24'h00_0003);
        step(10'h312, 4'h0, 1'b0);
        chk(24'({ptrs, skipped, carry_out}), 24'({4'hA, 4'h5, 2'h0, 2'b10}));
        go = 1'b0;
        @(posedge clk);
        #1;
        chk(24'({pc_advance, skipped}), 24'h00_0000);
        step(10'h3F0, 4'h0, 1'b0);
        chk(24'({ptrs, skipped}), 24'({4'hA, 4'h5, 2'h0, 1'b1}));
        step(PLX_OP_NOP, 4'hF, 1'b1);
        chk(24'({ptrs, pc_advance, skipped, port_zero}), 24'({4'hA, 4'h5, 2'h0, 6'h20}));
        step(10'h3C3, 4'h0, 1'b0);
        chk(24'({ptrs, skipped}), 24'({4'hC, 4'h3, 2'h0, 1'b0}));
        $display("test pointer loads done");
    endtask
    task automatic t_bank();
        for (int z = 0; z < 4; z++) begin
            step(PLX_OP_BANK | 10'(z), 4'h0, 1'b0);
            chk(24'(ptrs), 24'({4'hC, 4'h3, 2'(z)}));
        end
        $display("test bank loads done");
    endtask
    task automatic t_port();
        step(PLX_OP_BIT_OUT, 4'hE, 1'b1);
        chk(24'({single_port, port_zero, carry_out}), 24'h00_0001);
        step(PLX_OP_BIT_OUT, 4'h1, 1'b0);
        chk(24'({single_port, port_zero}), 24'h00_0010);
        step(PLX_OP_P0_OUT, 4'h9, 1'b0);
        chk(24'({single_port, port_zero}), 24'h00_0019);
        step(PLX_OP_P0_OUT, 4'h6, 1'b0);
        chk(24'({single_port, port_zero}), 24'h00_0016);
        $display("test port outputs done");
    endtask
    task automatic t_misc();
        step(10'h123, 4'h5, 1'b1);
        chk(24'({ptrs, single_port, port_zero, pc_advance, skipped, carry_out}),
            24'({4'hC, 4'h3, 2'h3, 1'b1, 4'h6, 3'b101}));
        step(10'h377, 4'h0, 1'b0);
        chk(24'(ptrs), 24'({4'h7, 4'h7, 2'h3}));
        rstn = 1'b0;
        @(posedge clk);
        #1;
        chk(24'({ptrs, single_port, port_zero, pc_advance, skipped}), 24'h00_0000);
        rstn = 1'b1;
        step(10'h3A5, 4'h0, 1'b0);
        chk(24'({ptrs, skipped}), 24'({4'hA, 4'h5, 2'h0, 1'b0}));
        $display("test foreign word and reset done");
    endtask
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 500) begin
            fail_count++;
            end_sim();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        #1;
        rstn = 1'b1;
        chk(24'({ptrs, single_port, port_zero, pc_advance, skipped}), 24'h00_0000);
        t_xy();
        t_bank();
        t_port();
        t_misc();
        end_sim();
    end
endmodule
